// File: qpf_pkg.sv
package qpf_pkg;
  // Phase encoding: one-hot position in the four-phase ring
  localparam int PHASE_COUNT      = 4;
  localparam int PC_WIDTH         = 13;
  localparam int INSTR_WIDTH      = 14;
  localparam int DATA_WIDTH       = 8;
  localparam logic [3:0] PHASE_RESET = 4'h1;

  // Register reset values: running, clock out on, port B all inputs
  localparam logic [3:0] CTRL_RESET   = 4'h9;
  localparam logic [7:0] PB_DIR_RESET = 8'hff;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFF_PORTB_OUT = 8'h10;
  localparam logic [7:0] OFF_PORTB_DIR = 8'h14;
  localparam logic [7:0] OFF_PORTB_PU  = 8'h18;
  localparam logic [7:0] OFF_PORTA_OUT = 8'h1c;
  localparam logic [7:0] OFF_REDIRECT  = 8'h20;

  // Control register fields
  localparam int CTRL_RC_MODE  = 0;
  localparam int CTRL_EXT_IRQ  = 1;
  localparam int CTRL_PROG     = 2;
  localparam int CTRL_RUN      = 3;

  // Interrupt status bits
  localparam int IRQ_EXT       = 0;
  localparam int IRQ_CHANGE    = 1;
  localparam int IRQ_FLUSH     = 2;
  localparam int IRQ_BITS      = 3;
endpackage : qpf_pkg

// File: quad_phase_fetch_pipeline.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module quad_phase_fetch_pipeline #(
  parameter int PC_W    = qpf_pkg::PC_WIDTH,
  parameter int INSTR_W = qpf_pkg::INSTR_WIDTH
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               master_clear_n,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Program memory
  output logic      [PC_W-1:0]    prog_counter,
  input  wire logic [INSTR_W-1:0] prog_data,
  output logic      [INSTR_W-1:0] instr_latch,
  output logic                    exec_valid,
  input  wire logic               exec_branch,
  input  wire logic [PC_W-1:0]    branch_target,
  // Phase strobes
  output logic      [3:0]         phase,
  output logic                    operand_read,
  output logic                    dest_write,
  // Oscillator output
  output logic                    osc_output_pin,
  // Port A line four
  input  wire logic               port_a_line4_in,
  output logic                    port_a_line4_out,
  output logic                    port_a_line4_oe,
  output logic                    timer_ext_clock_in,
  // Port B
  input  wire logic [7:0]         port_b_in,
  output logic      [7:0]         port_b_out,
  output logic      [7:0]         port_b_oe,
  output logic      [7:0]         port_b_pullup,
  output logic                    prog_clock,
  output logic                    prog_data_bit,
  // Interrupt
  output logic                    irq
);

  localparam int IRQ_BITS_W = qpf_pkg::IRQ_BITS;

  typedef struct packed {
    logic [3:0]          ph;
    logic                reset_sync1;
    logic                reset_sync2;
    logic                first_cycle;
    logic [PC_W-1:0]     pc;
    logic [INSTR_W-1:0]  fetched;
    logic [INSTR_W-1:0]  ir;
    logic                exec_v;
    logic                flush;
    logic                clkout;
    logic [7:0]          pb_s1;
    logic [7:0]          pb_s2;
    logic [7:0]          pb_prev;
    logic                pa_s1;
    logic                pa_s2;
    logic [3:0]          ctrl;
    logic [IRQ_BITS_W-1:0] irq_stat;
    logic [IRQ_BITS_W-1:0] irq_mask;
    logic [7:0]          pb_out;
    logic [7:0]          pb_dir;
    logic [7:0]          pb_pu;
    logic                pa_out;
    logic [PC_W-1:0]     redir_tgt;
    logic                redir_req;
    logic                dp_valid;
    logic                dp_write;
    logic [7:0]          dp_addr;
    logic [31:0]         rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic       in_reset;
  logic [7:0] pb_sync;
  logic       ext_edge;
  logic       chg_hit;
  logic       take_redirect;
  logic       run_ok;

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      qpf_pkg::OFF_CTRL:      r[3:0] = s.ctrl;
      qpf_pkg::OFF_STATUS:    r = {3'h0, s.ph, s.exec_v, s.flush, 10'h000, s.pc};
      qpf_pkg::OFF_IRQ_STAT:  r[IRQ_BITS_W-1:0] = s.irq_stat;
      qpf_pkg::OFF_IRQ_MASK:  r[IRQ_BITS_W-1:0] = s.irq_mask;
      qpf_pkg::OFF_PORTB_OUT: r[7:0] = s.pb_s2;
      qpf_pkg::OFF_PORTB_DIR: r[7:0] = s.pb_dir;
      qpf_pkg::OFF_PORTB_PU:  r[7:0] = s.pb_pu;
      qpf_pkg::OFF_PORTA_OUT: r[1:0] = {s.pa_s2, s.pa_out};
      qpf_pkg::OFF_REDIRECT:  r[PC_W-1:0] = s.redir_tgt;
      default:                r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // Core held while bus reset or master clear is active
  assign in_reset      = !s_q.reset_sync2;
  assign pb_sync       = s_q.pb_s2;
  assign ext_edge      = pb_sync[0] && !s_q.pb_prev[0] && s_q.ctrl[qpf_pkg::CTRL_EXT_IRQ];
  assign chg_hit       = |(pb_sync[7:4] ^ s_q.pb_prev[7:4]);
  assign take_redirect = s_q.exec_v && (exec_branch || s_q.redir_req);
  assign run_ok        = !in_reset && s_q.ctrl[qpf_pkg::CTRL_RUN];

  always_comb begin
    s_d = s_q;
    // Master clear crosses in like any pin
    s_d.reset_sync1 = master_clear_n;
    s_d.reset_sync2 = s_q.reset_sync1;
    s_d.pb_s1       = port_b_in;
    s_d.pb_s2       = s_q.pb_s1;
    s_d.pb_prev     = s_q.pb_s2;
    s_d.pa_s1       = port_a_line4_in;
    s_d.pa_s2       = s_q.pa_s1;

    if (in_reset) begin
      s_d.ph          = qpf_pkg::PHASE_RESET;
      s_d.pc          = '0;
      s_d.first_cycle = 1'b1;
      s_d.exec_v      = 1'b0;
      s_d.flush       = 1'b0;
      // Held in phase one, so the clock out stands high like phase one
      s_d.clkout      = 1'b1;
    end else if (s_q.ctrl[qpf_pkg::CTRL_RUN]) begin
      s_d.ph = {s_q.ph[2:0], s_q.ph[3]};
      // Clock out high in phases one and two, one quarter of input rate
      s_d.clkout = s_d.ph[0] || s_d.ph[1];
      if (s_q.ph[3]) begin
        s_d.fetched = prog_data;
        // Next cycle executes this fetch unless it must be discarded
        s_d.exec_v  = !take_redirect;
        s_d.flush   = take_redirect;
        s_d.first_cycle = 1'b0;
        if (take_redirect) begin
          s_d.pc        = s_q.redir_req ? s_q.redir_tgt : branch_target;
          s_d.redir_req = 1'b0;
        end
      end
      if (s_q.ph[3]) begin
        s_d.ir = prog_data;
      end
      if (s_q.ph[0] && !s_q.flush) begin
        s_d.pc = s_q.pc + PC_W'(1);
      end
    end

    // Interrupt status: set wins over write-one clear
    if (s_q.dp_valid && s_q.dp_write && s_q.dp_addr == qpf_pkg::OFF_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~hwdata[IRQ_BITS_W-1:0];
    end
    if (ext_edge) s_d.irq_stat[qpf_pkg::IRQ_EXT] = 1'b1;
    if (chg_hit) s_d.irq_stat[qpf_pkg::IRQ_CHANGE] = 1'b1;
    if (s_q.ph[3] && take_redirect && !in_reset) begin
      s_d.irq_stat[qpf_pkg::IRQ_FLUSH] = 1'b1;
    end

    // Bus data phase write
    if (s_q.dp_valid && s_q.dp_write) begin
      unique case (s_q.dp_addr)
        qpf_pkg::OFF_CTRL:      s_d.ctrl = hwdata[3:0];
        qpf_pkg::OFF_IRQ_MASK:  s_d.irq_mask = hwdata[IRQ_BITS_W-1:0];
        qpf_pkg::OFF_PORTB_OUT: s_d.pb_out = hwdata[7:0];
        qpf_pkg::OFF_PORTB_DIR: s_d.pb_dir = hwdata[7:0];
        qpf_pkg::OFF_PORTB_PU:  s_d.pb_pu = hwdata[7:0];
        qpf_pkg::OFF_PORTA_OUT: s_d.pa_out = hwdata[0];
        qpf_pkg::OFF_REDIRECT: begin
          s_d.redir_tgt = hwdata[PC_W-1:0];
          s_d.redir_req = 1'b1;
        end
        default: ;
      endcase
    end

    // Bus address phase
    s_d.dp_valid = hsel && hready && htrans[1];
    s_d.dp_write = hwrite;
    s_d.dp_addr  = haddr[7:0];
    s_d.rdata    = read_mux(s_q, haddr[7:0]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.ph       <= qpf_pkg::PHASE_RESET;
      s_q.pb_dir   <= qpf_pkg::PB_DIR_RESET;
      s_q.pa_out   <= 1'b1;
      s_q.ctrl     <= qpf_pkg::CTRL_RESET;
      s_q.first_cycle <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign prog_counter = s_q.pc;
  assign instr_latch  = s_q.ir;
  assign exec_valid   = s_q.exec_v && !in_reset;
  assign phase        = s_q.ph;
  assign operand_read = exec_valid && s_q.ph[1];
  assign dest_write   = exec_valid && s_q.ph[3];
  assign osc_output_pin = s_q.ctrl[qpf_pkg::CTRL_RC_MODE] && s_q.clkout;

  // Open drain: only pulls low
  assign port_a_line4_out   = 1'b0;
  assign port_a_line4_oe    = !s_q.pa_out;
  assign timer_ext_clock_in = s_q.pa_s2;

  // Programming mode hands lines six and seven to the programmer
  assign port_b_out    = s_q.pb_out;
  for (genvar i = 0; i < 8; i++) begin : g_port_b
    logic prog_line;
    assign prog_line        = s_q.ctrl[qpf_pkg::CTRL_PROG] && (i >= 6);
    assign port_b_oe[i]     = !s_q.pb_dir[i] && !prog_line;
    // Pull-up only on an input line, never fighting the driver
    assign port_b_pullup[i] = s_q.pb_pu[i] && s_q.pb_dir[i];
  end
  assign prog_clock    = s_q.ctrl[qpf_pkg::CTRL_PROG] && pb_sync[6];
  assign prog_data_bit = s_q.ctrl[qpf_pkg::CTRL_PROG] && pb_sync[7];

  assign irq = |(s_q.irq_stat & s_q.irq_mask);


  // Pipeline checks up to the clock out check, except the operand phase check, stand down while the core is held or stopped
  property p_phase_order;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      s_q.ph[0] |=> s_q.ph[1] ##1 s_q.ph[2] ##1 s_q.ph[3];
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phase order broken");

  property p_pc_step;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      (s_q.ph[0] && !s_q.flush) |=> (s_q.pc == $past(s_q.pc) + PC_W'(1));
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("counter did not step in phase one");

  property p_fetch_latch;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      s_q.ph[3] |=> (instr_latch == $past(prog_data));
  endproperty
  a_fetch_latch: assert property (p_fetch_latch)
    else $error("fetched word not latched");

  property p_exec_follow;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      (s_q.ph[3] && !take_redirect) |=> exec_valid;
  endproperty
  a_exec_follow: assert property (p_exec_follow)
    else $error("fetched word not executed");

  property p_branch_stall;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      (s_q.ph[3] && take_redirect) |=> s_q.flush;
  endproperty
  a_branch_stall: assert property (p_branch_stall)
    else $error("redirect did not cost a cycle");

  property p_flush_drop;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      (s_q.ph[3] && take_redirect) |=> !exec_valid [*4];
  endproperty
  a_flush_drop: assert property (p_flush_drop)
    else $error("flushed word executed");

  property p_branch_target;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      (s_q.ph[3] && take_redirect && !s_q.redir_req) |=> (s_q.pc == $past(branch_target));
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("counter missed the target");

  property p_operand_phase;
    @(posedge hclk) disable iff (!hresetn)
      (operand_read || dest_write) |-> (exec_valid && (s_q.ph[1] || s_q.ph[3]));
  endproperty
  a_operand_phase: assert property (p_operand_phase)
    else $error("data access outside its phase");

  property p_clkout_rate;
    @(posedge hclk) disable iff (!hresetn || !run_ok)
      s_q.ctrl[qpf_pkg::CTRL_RC_MODE] |-> (osc_output_pin == (s_q.ph[0] || s_q.ph[1]));
  endproperty
  a_clkout_rate: assert property (p_clkout_rate)
    else $error("clock out off its phases");

  property p_reset_phase;
    @(posedge hclk) disable iff (!hresetn)
      in_reset |=> ((s_q.ph == qpf_pkg::PHASE_RESET) && !exec_valid);
  endproperty
  a_reset_phase: assert property (p_reset_phase)
    else $error("core ran during master clear");

  property p_first_fetch;
    @(posedge hclk) disable iff (!hresetn)
      s_q.first_cycle |-> !exec_valid;
  endproperty
  a_first_fetch: assert property (p_first_fetch)
    else $error("first cycle executed a word");

  property p_open_drain;
    @(posedge hclk) disable iff (!hresetn)
      port_a_line4_oe |-> !port_a_line4_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("port A line four drove high");

  property p_ext_set;
    @(posedge hclk) disable iff (!hresetn)
      ext_edge |=> s_q.irq_stat[qpf_pkg::IRQ_EXT];
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("external edge not flagged");

  property p_change_set;
    @(posedge hclk) disable iff (!hresetn)
      chg_hit |=> s_q.irq_stat[qpf_pkg::IRQ_CHANGE];
  endproperty
  a_change_set: assert property (p_change_set)
    else $error("line change not flagged");

  property p_prog_hand;
    @(posedge hclk) disable iff (!hresetn)
      s_q.ctrl[qpf_pkg::CTRL_PROG] |-> (port_b_oe[7:6] == 2'b00);
  endproperty
  a_prog_hand: assert property (p_prog_hand)
    else $error("programming lines still driven");
endmodule : quad_phase_fetch_pipeline

// File: prog_mem_model.sv
`timescale 1ns/1ps
// Program memory; word is a fixed function of its address so the bench can predict it
module prog_mem_model (
  // Fetch side
  input  wire logic [12:0] prog_counter,
  output logic      [13:0] prog_data
);
  // Combinational, so the word is settled well before the latching phase
  assign prog_data = {1'b0, prog_counter} ^ 14'h2a5a;
endmodule : prog_mem_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        hclk, hresetn, master_clear_n, hwrite, hready, hreadyout;
  logic        exec_valid, exec_branch, operand_read, dest_write, osc_output_pin;
  logic        port_a_line4_in, port_a_line4_out, port_a_line4_oe, timer_ext_clock_in;
  logic        prog_clock, prog_data_bit, irq, mon, st, fl, okpc;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, sd;
  logic [12:0] prog_counter, branch_target, npc;
  logic [13:0] prog_data, instr_latch, w;
  logic [3:0]  phase, pv;
  logic [7:0]  port_b_in, port_b_oe, port_b_pullup, port_b_out;
  int          err_count, n_checks;
  assign hready = hreadyout;

  quad_phase_fetch_pipeline dut_u (
    .hclk, .hresetn, .master_clear_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp(), .prog_counter,
    .prog_data, .instr_latch, .exec_valid, .exec_branch, .branch_target, .phase,
    .operand_read, .dest_write, .osc_output_pin, .port_a_line4_in,
    .port_a_line4_out, .port_a_line4_oe, .timer_ext_clock_in, .port_b_in,
    .port_b_out, .port_b_oe, .port_b_pullup, .prog_clock, .prog_data_bit, .irq);
  prog_mem_model mem_u (.prog_counter, .prog_data);

  always #10 hclk = ~hclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [13:0] mem(input logic [12:0] a);
    return {1'b0, a} ^ 14'h2a5a;
  endfunction : mem

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Caller must stand just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Long enough for the two-flop pin synchronisers
  task automatic nap;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask : nap

  task automatic osc_chk(input logic rc);
    repeat (8) @(negedge hclk) chk("osc", 32'(rc & (phase[0] | phase[1])), 32'(osc_output_pin));
    @(posedge hclk);
  endtask : osc_chk

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Pipeline monitor; values read mid-cycle once they have settled
  always @(negedge hclk) begin
    if (!mon) begin
      pv = 4'h8;
      st = 1;
      fl = 1;
      okpc = 0;
    end else begin
      if (!(st && phase === 4'h1)) chk("phase", 32'({pv[2:0], pv[3]}), 32'(phase));
      if (phase !== 4'h1) st = 0;
      pv = phase;
      chk("oprd", 32'(phase[1] & exec_valid), 32'(operand_read));
      chk("dwr", 32'(phase[3] & exec_valid), 32'(dest_write));
      if (phase === 4'h2) begin
        chk("exec", 32'(!fl), 32'(exec_valid));
        if (!fl) chk("latch", 32'(w), 32'(instr_latch));
      end
      if (phase === 4'h8) begin
        if (okpc) chk("pc", 32'(npc), 32'(prog_counter));
        w = mem(prog_counter);
        fl = exec_valid & exec_branch;
        npc = fl ? branch_target : prog_counter + 13'h1;
        okpc = 1;
      end
    end
  end

  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial begin
    {hclk, hresetn, hwrite, htrans, haddr, hwdata, exec_branch, branch_target} = '0;
    {master_clear_n, port_a_line4_in, port_b_in, mon, err_count, n_checks} = '0;
    master_clear_n = 1;
    sd = 32'h53;
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    mon <= 1;
    repeat (2) @(posedge hclk);
    bus(qpf_pkg::OFF_CTRL, 0, 0);
    chk("ctrl", 32'h9, rd);
    bus(8'h40, 1, 32'hffff_ffff);
    bus(8'h40, 0, 0);
    chk("unmapped", 32'h0, rd);
    osc_chk(1);
    repeat (60) begin
      do @(posedge hclk); while (phase !== 4'h2);
      sd = xs(sd);
      exec_branch <= sd[0] & sd[1];
      branch_target <= sd[14:2];
      port_b_in <= {4'h0, sd[18:16], 1'b0};
      repeat (2) @(posedge hclk);
      exec_branch <= 0;
    end
    bus(qpf_pkg::OFF_CTRL, 1, 32'h8);
    osc_chk(0);
    for (int i = 0; i < 5; i++) begin
      sd = (i == 0) ? 32'hff0f : xs(sd);
      bus(qpf_pkg::OFF_PORTB_DIR, 1, {24'h0, sd[7:0]});
      bus(qpf_pkg::OFF_PORTB_PU, 1, {24'h0, sd[15:8]});
      bus(qpf_pkg::OFF_PORTB_OUT, 1, {24'h0, sd[23:16]});
      nap();
      chk("pullup", 32'(sd[15:8] & sd[7:0]), 32'(port_b_pullup));
      chk("pb_oe", {24'h0, ~sd[7:0]}, 32'(port_b_oe));
      chk("pb_out", {24'h0, sd[23:16]}, 32'(port_b_out));
      @(posedge hclk);
    end
    for (int v = 0; v < 2; v++) begin
      bus(qpf_pkg::OFF_PORTA_OUT, 1, 32'(v));
      port_a_line4_in <= v[0];
      nap();
      chk("pa_oe", 32'(!v[0]), 32'(port_a_line4_oe));
      chk("pa_out", 32'h0, 32'(port_a_line4_out));
      chk("tmr_clk", 32'(v[0]), 32'(timer_ext_clock_in));
      @(posedge hclk);
    end
    bus(qpf_pkg::OFF_CTRL, 1, 32'hb);
    bus(qpf_pkg::OFF_IRQ_MASK, 1, 32'h1);
    bus(qpf_pkg::OFF_IRQ_STAT, 1, 32'h7);
    port_b_in <= 8'h01;
    nap();
    chk("irq", 32'h1, 32'(irq));
    @(posedge hclk);
    bus(qpf_pkg::OFF_IRQ_STAT, 0, 0);
    chk("stat", 32'h1, rd & 32'h3);
    bus(qpf_pkg::OFF_IRQ_MASK, 1, 32'h0);
    nap();
    chk("irq", 32'h0, 32'(irq));
    @(posedge hclk);
    bus(qpf_pkg::OFF_IRQ_STAT, 1, 32'h1);
    port_b_in <= 8'h21;
    nap();
    @(posedge hclk);
    bus(qpf_pkg::OFF_IRQ_STAT, 0, 0);
    chk("stat", 32'h2, rd & 32'h3);
    bus(qpf_pkg::OFF_CTRL, 1, 32'hd);
    for (int v = 0; v < 2; v++) begin
      port_b_in <= v[0] ? 8'h80 : 8'h40;
      nap();
      chk("prg_clk", 32'(!v[0]), 32'(prog_clock));
      chk("prg_dat", 32'(v[0]), 32'(prog_data_bit));
      chk("prg_oe", 32'h0, 32'(port_b_oe[7:6]));
      @(posedge hclk);
    end
    mon <= 0;
    master_clear_n <= 0;
    repeat (6) @(posedge hclk);
    @(negedge hclk);
    chk("mc_exec", 32'h0, 32'(exec_valid));
    chk("mc_phase", 32'h1, 32'(phase));
    @(posedge hclk);
    master_clear_n <= 1;
    mon <= 1;
    repeat (40) @(posedge hclk);
    print_verdict();
  end
endmodule : tb_top
